/* verilog/lcdc_cfg.svh */
// Functional notes
// - 00011..00110 prefixes load region coefficients
// - Prefix 0100 loads pump code high nibble
// - Prefix 0101 loads pump code low nibble
// - Pump code 0 is 3 V, C8h 9 V
// - 0011100x sets display on; off grounds outputs
// - Host blinks display by toggling enable
// - Prefix 00000 loads drive mode field
// - Modes 000/011/101/111 give 1:8, 44 segments
// - Mode 110 gives 1:6, 46 segments
// - Mode 100 gives 1:4, 44 segments
// - Mode 010 gives 1:2, 44 segments
// - Mode 001 gives static, 44 segments
// - Prefix 110001 loads bias; 00/01 quarter
// - Bias ignored in static drive
// - Prefix 10 loads RAM pointer 0..63; data is written only at 0..45
// - Data bytes written from pointer address
// - Frame-frequency command sets frame and clock
// - Prefix 011 carries five-bit prescaler code
`ifndef LCDC_CFG_SVH
`define LCDC_CFG_SVH
`define LCDC_PFX_COEF_A   5'h03
`define LCDC_PFX_COEF_B   5'h04
`define LCDC_PFX_COEF_C   5'h05
`define LCDC_PFX_COEF_D   5'h06
`define LCDC_PFX_PUMP_HI  4'h4
`define LCDC_PFX_PUMP_LO  4'h5
`define LCDC_PFX_DISP     7'h1C
`define LCDC_PFX_MODE     5'h00
`define LCDC_PFX_BIAS     6'h31
`define LCDC_PFX_PTR      2'h2
`define LCDC_PFX_FRAME    3'h3
`define LCDC_RST_COEF     3'h0
`define LCDC_RST_PUMP     8'h00
`define LCDC_RST_MODE     3'h0
`define LCDC_RST_BIAS     2'h0
`define LCDC_RST_FRAME    5'h0E
`define LCDC_PTR_MAX      6'h2D
`define LCDC_PUMP_MAX     8'hC8
`define LCDC_SEG_MAX      6'h2E
`endif

/* verilog/lcdc_pkg.sv */
package lcdc_pkg;
	typedef enum logic [2:0] {
		LCDC_MUX_STATIC,
		LCDC_MUX_2,
		LCDC_MUX_4,
		LCDC_MUX_6,
		LCDC_MUX_8
	} lcdc_mux_t;

	typedef enum logic [1:0] {
		LCDC_BIAS_NONE,
		LCDC_BIAS_HALF,
		LCDC_BIAS_THIRD,
		LCDC_BIAS_QUARTER
	} lcdc_bias_t;

	typedef enum logic {
		LCDC_HS_IDLE,
		LCDC_HS_SEND
	} lcdc_hs_t;
endpackage : lcdc_pkg

/* verilog/lcdc_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Byte link: host presents a byte with a flag telling command or data
interface lcdc_if;
	logic       valid;
	logic       is_cmd;
	logic [7:0] data;
	logic       ready;

	modport dev  (input valid, input is_cmd, input data, output ready);
	modport host (output valid, output is_cmd, output data, input ready);
endinterface : lcdc_if
`default_nettype wire

/* verilog/lcdc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host end: queues one byte at a time onto the link
module lcdc_host (
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	lcdc_if.host       bus,
	input  wire logic  i_req,
	input  wire logic  i_is_cmd,
	input  wire logic [7:0] i_byte,
	output logic       o_busy
);
	typedef struct packed {
		lcdc_pkg::lcdc_hs_t st;
		logic               is_cmd;
		logic [7:0]         data;
	} lcdc_host_st_t;

	lcdc_host_st_t s_q, s_d;

	// Accept a request while idle, hold it until the device takes it
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			lcdc_pkg::LCDC_HS_IDLE: begin
				if (i_req) begin
					s_d.st     = lcdc_pkg::LCDC_HS_SEND;
					s_d.is_cmd = i_is_cmd;
					s_d.data   = i_byte;
				end
			end
			lcdc_pkg::LCDC_HS_SEND: begin
				if (bus.ready) begin
					s_d.st = lcdc_pkg::LCDC_HS_IDLE;
				end
			end
			default: s_d.st = lcdc_pkg::LCDC_HS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{lcdc_pkg::LCDC_HS_IDLE, 1'b0, 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.valid  = (s_q.st == lcdc_pkg::LCDC_HS_SEND);
	assign bus.is_cmd = s_q.is_cmd;
	assign bus.data   = s_q.data;
	assign o_busy     = (s_q.st == lcdc_pkg::LCDC_HS_SEND);
endmodule : lcdc_host
`default_nettype wire

/* verilog/lcdc_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_cfg.svh"
// Device end: command decoder and stored settings
module lcdc_dev (
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	lcdc_if.dev        bus,
	output logic [2:0] o_coeff_region_a,
	output logic [2:0] o_coeff_region_b,
	output logic [2:0] o_coeff_region_c,
	output logic [2:0] o_coeff_region_d,
	output logic [7:0] o_pump_target_code,
	output logic       o_pump_code_over,
	output logic       o_display_on,
	output logic       o_outputs_grounded,
	output logic [2:0] o_drive_mode,
	output lcdc_pkg::lcdc_mux_t o_mux,
	output logic [3:0] o_backplanes,
	output logic [5:0] o_segments,
	output logic [1:0] o_bias_field,
	output lcdc_pkg::lcdc_bias_t o_bias,
	output logic [5:0] o_ram_ptr,
	output logic [4:0] o_frame_code,
	output logic       o_frame_upd,
	output logic       o_ram_we,
	output logic [5:0] o_ram_addr,
	output logic [7:0] o_ram_wdata
);
	typedef struct packed {
		logic [2:0] ca, cb, cc, cd;
		logic [7:0] pump;
		logic       disp;
		logic [2:0] mode;
		logic [1:0] bias;
		logic [5:0] ptr;
		logic [4:0] frame;
		logic       frame_upd;
		logic       we;
		logic [5:0] addr;
		logic [7:0] wdata;
		lcdc_pkg::lcdc_mux_t  mux;
		lcdc_pkg::lcdc_bias_t bias_sel;
		logic       over;
		logic       gnd;
		logic [3:0] bp;
		logic [5:0] seg;
	} lcdc_dev_st_t;

	// Pointer limit must stay below the segment count
	if (`LCDC_PTR_MAX >= `LCDC_SEG_MAX) begin : g_bad_ptr
		$error("pointer limit beyond segment count");
	end

	lcdc_dev_st_t s_q, s_d;

	// Mode field to multiplex setting
	function automatic lcdc_pkg::lcdc_mux_t mux_of(input logic [2:0] m);
		case (m)
			3'h6:    mux_of = lcdc_pkg::LCDC_MUX_6;
			3'h4:    mux_of = lcdc_pkg::LCDC_MUX_4;
			3'h2:    mux_of = lcdc_pkg::LCDC_MUX_2;
			3'h1:    mux_of = lcdc_pkg::LCDC_MUX_STATIC;
			default: mux_of = lcdc_pkg::LCDC_MUX_8;
		endcase
	endfunction

	// Backplane count of a multiplex setting
	function automatic logic [3:0] bp_of(input lcdc_pkg::lcdc_mux_t x);
		case (x)
			lcdc_pkg::LCDC_MUX_8: bp_of = 4'h8;
			lcdc_pkg::LCDC_MUX_6: bp_of = 4'h6;
			lcdc_pkg::LCDC_MUX_4: bp_of = 4'h4;
			lcdc_pkg::LCDC_MUX_2: bp_of = 4'h2;
			default:              bp_of = 4'h1;
		endcase
	endfunction

	// Segment count, 46 only in 1:6 drive
	function automatic logic [5:0] seg_of(input lcdc_pkg::lcdc_mux_t x);
		if (x == lcdc_pkg::LCDC_MUX_6) begin
			seg_of = `LCDC_SEG_MAX;
		end else begin
			seg_of = 6'h2C;
		end
	endfunction

	// Pointer advance, wraps after the last RAM column
	function automatic logic [5:0] next_ptr(input logic [5:0] p);
		if (p >= `LCDC_PTR_MAX) begin
			next_ptr = 6'h00;
		end else begin
			next_ptr = p + 6'h01;
		end
	endfunction

	// Bias field to bias level, ignored in static drive
	function automatic lcdc_pkg::lcdc_bias_t bias_of(input logic [1:0] b,
			input logic [2:0] m);
		if (mux_of(m) == lcdc_pkg::LCDC_MUX_STATIC) begin
			bias_of = lcdc_pkg::LCDC_BIAS_NONE;
		end else begin
			case (b)
				2'h3:    bias_of = lcdc_pkg::LCDC_BIAS_THIRD;
				2'h2:    bias_of = lcdc_pkg::LCDC_BIAS_HALF;
				default: bias_of = lcdc_pkg::LCDC_BIAS_QUARTER;
			endcase
		end
	endfunction

	logic [7:0] b;
	assign b = bus.data;

	// Decode one byte per accepted transfer
	always_comb begin
		s_d           = s_q;
		s_d.frame_upd = 1'b0;
		s_d.we        = 1'b0;
		if (bus.valid && bus.is_cmd) begin
			if (b[7:3] == `LCDC_PFX_COEF_A) s_d.ca = b[2:0];
			else if (b[7:3] == `LCDC_PFX_COEF_B) s_d.cb = b[2:0];
			else if (b[7:3] == `LCDC_PFX_COEF_C) s_d.cc = b[2:0];
			else if (b[7:3] == `LCDC_PFX_COEF_D) s_d.cd = b[2:0];
			else if (b[7:4] == `LCDC_PFX_PUMP_HI) s_d.pump[7:4] = b[3:0];
			else if (b[7:4] == `LCDC_PFX_PUMP_LO) s_d.pump[3:0] = b[3:0];
			else if (b[7:1] == `LCDC_PFX_DISP) s_d.disp = b[0];
			else if (b[7:3] == `LCDC_PFX_MODE) s_d.mode = b[2:0];
			else if (b[7:2] == `LCDC_PFX_BIAS) s_d.bias = b[1:0];
			else if (b[7:6] == `LCDC_PFX_PTR) s_d.ptr = b[5:0];
			else if (b[7:5] == `LCDC_PFX_FRAME) begin
				s_d.frame     = b[4:0];
				s_d.frame_upd = 1'b1;
			end
			// Anything else falls through untouched
		end else if (bus.valid) begin
			// Data byte goes to RAM at pointer 0..45, pointer advances
			s_d.we    = (s_q.ptr <= `LCDC_PTR_MAX);
			s_d.addr  = s_q.ptr;
			s_d.wdata = b;
			s_d.ptr   = next_ptr(s_q.ptr);
		end
		s_d.mux      = mux_of(s_d.mode);
		s_d.bias_sel = bias_of(s_d.bias, s_d.mode);
		// Decodes registered so every output but bus.ready comes from a flop
		s_d.over     = (s_d.pump > `LCDC_PUMP_MAX); // Beyond 9 V code
		s_d.gnd      = ~s_d.disp;
		s_d.bp       = bp_of(s_d.mux);
		s_d.seg      = seg_of(s_d.mux);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{
				ca:        `LCDC_RST_COEF,
				cb:        `LCDC_RST_COEF,
				cc:        `LCDC_RST_COEF,
				cd:        `LCDC_RST_COEF,
				pump:      `LCDC_RST_PUMP,
				disp:      1'b0,
				mode:      `LCDC_RST_MODE,
				bias:      `LCDC_RST_BIAS,
				ptr:       6'h00,
				frame:     `LCDC_RST_FRAME,
				frame_upd: 1'b0,
				we:        1'b0,
				addr:      6'h00,
				wdata:     8'h00,
				mux:       lcdc_pkg::LCDC_MUX_8,
				bias_sel:  lcdc_pkg::LCDC_BIAS_QUARTER,
				over:      1'b0,
				gnd:       1'b1,
				bp:        4'h8,
				seg:       6'h2C
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.ready          = 1'b1;
	assign o_coeff_region_a   = s_q.ca;
	assign o_coeff_region_b   = s_q.cb;
	assign o_coeff_region_c   = s_q.cc;
	assign o_coeff_region_d   = s_q.cd;
	assign o_pump_target_code = s_q.pump;
	assign o_pump_code_over   = s_q.over;
	assign o_display_on       = s_q.disp;
	assign o_outputs_grounded = s_q.gnd;
	assign o_drive_mode       = s_q.mode;
	assign o_mux              = s_q.mux;
	assign o_backplanes       = s_q.bp;
	assign o_segments         = s_q.seg;
	assign o_bias_field       = s_q.bias;
	assign o_bias             = s_q.bias_sel;
	assign o_ram_ptr          = s_q.ptr;
	assign o_frame_code       = s_q.frame;
	assign o_frame_upd        = s_q.frame_upd;
	assign o_ram_we           = s_q.we;
	assign o_ram_addr         = s_q.addr;
	assign o_ram_wdata        = s_q.wdata;
endmodule : lcdc_dev
`default_nettype wire

/* test/lcdc_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the byte link and the region C coefficient, pump code, display, mode, bias field, pointer and frame settings decoded from it
module lcdc_asserts (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       valid,
	input wire logic       is_cmd,
	input wire logic [7:0] data,
	input wire logic [2:0] o_coeff_region_c,
	input wire logic [7:0] o_pump_target_code,
	input wire logic       o_display_on,
	input wire logic       o_outputs_grounded,
	input wire logic [2:0] o_drive_mode,
	input wire logic [1:0] o_bias_field,
	input wire logic [5:0] o_ram_ptr,
	input wire logic [4:0] o_frame_code,
	input wire logic       o_frame_upd
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire cmd = valid && is_cmd;
	chk_coeff_load : assert property (
		cmd && data[7:3] == 5'h05 |=> o_coeff_region_c == $past(data[2:0])) else $error("coeff load");
	chk_pump_high : assert property (
		cmd && data[7:4] == 4'h4 |=> o_pump_target_code[7:4] == $past(data[3:0])) else $error("pump hi");
	chk_pump_low : assert property (
		cmd && data[7:4] == 4'h5 |=> o_pump_target_code[3:0] == $past(data[3:0])) else $error("pump lo");
	chk_display_flag : assert property (
		cmd && data[7:1] == 7'h1C |=> o_display_on == $past(data[0])) else $error("display flag");
	chk_outputs_ground : assert property (
		o_outputs_grounded == !o_display_on) else $error("grounding");
	chk_mode_load : assert property (
		cmd && data[7:3] == 5'h00 |=> o_drive_mode == $past(data[2:0])) else $error("mode load");
	chk_bias_load : assert property (
		cmd && data[7:2] == 6'h31 |=> o_bias_field == $past(data[1:0])) else $error("bias load");
	chk_ptr_load : assert property (
		cmd && data[7:6] == 2'h2 |=> o_ram_ptr == $past(data[5:0])) else $error("pointer load");
	chk_frame_load : assert property (
		cmd && data[7:5] == 3'h3 |=> o_frame_upd && o_frame_code == $past(data[4:0]))
		else $error("frame load");
	chk_frame_cause : assert property (
		o_frame_upd |-> $past(cmd && data[7:5] == 3'h3)) else $error("stray frame pulse");
	chk_unknown_still : assert property (
		cmd && data == 8'hFF |=> $stable(o_drive_mode) && $stable(o_bias_field))
		else $error("unknown byte changed settings");
endmodule // lcdc_asserts
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk, i_rst_n, req, is_cmd, busy, on, ewe, efu, c, o_pump_code_over, o_display_on;
	logic o_outputs_grounded, o_frame_upd, o_ram_we;
	logic [7:0] byt, pump, ewd, b, o_pump_target_code, o_ram_wdata;
	logic [2:0] co [4];
	logic [2:0] md, o_coeff_region_a, o_coeff_region_b, o_coeff_region_c, o_coeff_region_d;
	logic [2:0] o_drive_mode;
	logic [1:0] bs, o_bias_field;
	logic [5:0] ptr, ead, o_ram_ptr, o_segments, o_ram_addr;
	logic [4:0] frm, o_frame_code;
	logic [3:0] o_backplanes;
	lcdc_pkg::lcdc_bias_t o_bias;
	int errors, checks, r;
	lcdc_if bus ();
	lcdc_host u_lcdc_host (.i_clk, .i_rst_n, .bus(bus), .i_req(req), .i_is_cmd(is_cmd),
		.i_byte(byt), .o_busy(busy));
	lcdc_dev u_lcdc_dev (.i_clk, .i_rst_n, .bus(bus), .o_coeff_region_a, .o_coeff_region_b,
		.o_coeff_region_c, .o_coeff_region_d, .o_pump_target_code, .o_pump_code_over,
		.o_display_on, .o_outputs_grounded, .o_drive_mode, .o_mux(), .o_backplanes, .o_segments,
		.o_bias_field, .o_bias, .o_ram_ptr, .o_frame_code, .o_frame_upd, .o_ram_we, .o_ram_addr,
		.o_ram_wdata);
	lcdc_asserts u_lcdc_asserts (.i_clk, .i_rst_n, .valid(bus.valid), .is_cmd(bus.is_cmd),
		.data(bus.data), .o_coeff_region_c, .o_pump_target_code, .o_display_on,
		.o_outputs_grounded, .o_drive_mode, .o_bias_field, .o_ram_ptr, .o_frame_code, .o_frame_upd);
	// Clock and watchdog
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#200_000;
		errors++;
		wrap_up;
	end
	function automatic logic [7:0] bpf(input logic [2:0] m);
		return m == 3'h1 ? 8'h01 : m == 3'h2 ? 8'h02 : m == 3'h4 ? 8'h04 : m == 3'h6 ? 8'h06 : 8'h08;
	endfunction
	function automatic logic [7:0] biasf(input logic [2:0] m, input logic [1:0] v);
		if (m == 3'h1) return 8'(lcdc_pkg::LCDC_BIAS_NONE);
		if (v == 2'h2) return 8'(lcdc_pkg::LCDC_BIAS_HALF);
		return 8'(v == 2'h3 ? lcdc_pkg::LCDC_BIAS_THIRD : lcdc_pkg::LCDC_BIAS_QUARTER);
	endfunction
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic init;
		co = '{3'h0, 3'h0, 3'h0, 3'h0};
		{pump, on, md, bs, ptr, frm, ewe, efu} = {8'h00, 1'b0, 3'h0, 2'h0, 6'h00, 5'h0E, 2'h0};
	endtask
	// Expected settings after one accepted byte
	task automatic upd(input logic ic, input logic [7:0] v);
		{ewe, efu} = 2'h0;
		if (!ic) begin
			{ewe, ead, ewd} = {ptr <= 6'h2D, ptr, v};
			ptr = ptr >= 6'h2D ? 6'h00 : ptr + 6'h01;
		end
		else if (v[7:3] >= 5'h03 && v[7:3] <= 5'h06) co[2'(v[7:3] - 5'h03)] = v[2:0];
		else if (v[7:4] == 4'h4) pump[7:4] = v[3:0];
		else if (v[7:4] == 4'h5) pump[3:0] = v[3:0];
		else if (v[7:1] == 7'h1C) on = v[0];
		else if (v[7:3] == 5'h00) md = v[2:0];
		else if (v[7:2] == 6'h31) bs = v[1:0];
		else if (v[7:6] == 2'h2) ptr = v[5:0];
		else if (v[7:5] == 3'h3) {frm, efu} = {v[4:0], 1'b1};
	endtask
	task automatic verify;
		cmp(8'(o_coeff_region_a), 8'(co[0]));
		cmp({o_coeff_region_b, o_coeff_region_c}, {co[1], co[2]});
		cmp(8'(o_coeff_region_d), 8'(co[3]));
		cmp(o_pump_target_code, pump);
		cmp(8'(o_pump_code_over), 8'(pump > 8'hC8));
		cmp({o_display_on, o_outputs_grounded}, {on, !on});
		cmp(8'(o_drive_mode), 8'(md));
		cmp(8'(o_backplanes), bpf(md));
		cmp(8'(o_segments), md == 3'h6 ? 8'h2E : 8'h2C);
		cmp({4'h0, o_bias_field, 2'(o_bias)}, {4'h0, bs, 2'(biasf(md, bs))});
		cmp(8'(o_ram_ptr), 8'(ptr));
		cmp({o_frame_upd, o_frame_code}, {efu, frm});
		cmp(8'(o_ram_we), 8'(ewe));
		if (ewe) cmp({o_ram_addr, o_ram_wdata}, {ead, ewd});
	endtask
	// One byte through the host, checked in the cycle after it is taken
	task automatic send(input logic ic, input logic [7:0] v);
		int n;
		n = 0;
		{req, is_cmd, byt} = {1'b1, ic, v};
		@(posedge i_clk) #1;
		req = 0;
		while (busy !== 1'b0 && n < 20) begin
			@(posedge i_clk) #1;
			n++;
		end
		upd(ic, v);
		verify;
		@(posedge i_clk) #1;
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Corner cases first, then random bytes, with a reset in mid-run
	initial begin
		{i_rst_n, req, is_cmd, byt} = 11'h0;
		init;
		repeat (12) @(posedge i_clk);
		#1 i_rst_n = 1;
		r = $urandom(73);
		verify;
		for (int m = 0; m < 8; m++) begin
			send(1, 8'(m));
			for (int k = 0; k < 4; k++) send(1, 8'hC4 | 8'(k));
		end
		for (int m = 0; m < 8; m++) send(1, 8'(m));
		$display("test modes done");
		foreach (co[k]) send(1, 8'h1D + 8'(k * 8));
		send(1, 8'h4C);
		send(1, 8'h58);
		send(1, 8'h59);
		repeat (3) begin
			send(1, 8'h39);
			send(1, 8'h38);
		end
		send(1, 8'hAC);
		repeat (3) send(0, 8'($urandom));
		send(1, 8'hFF);
		send(1, 8'hD0);
		send(1, 8'h08);
		send(1, 8'h3A);
		send(1, 8'h7F);
		$display("test corners done");
		i_rst_n = 0;
		init;
		@(posedge i_clk) #1;
		verify;
		i_rst_n = 1;
		repeat (300) begin
			{c, b} = 9'($urandom);
			if (c && b[7:6] == 2'h2 && b[5:0] > 6'h2D) b[5] = 0;
			send(c, b);
		end
		$display("test random done");
		wrap_up;
	end
endmodule // tb
`default_nettype wire
